// ===== smcr_config_bank.v
/*
 * smcr_config_bank.v: per-chip configuration and readback registers of a
 * static memory controller, with the memory-side pin modes they steer.
 * Assumes the programming port gives one-cycle sel/write strobes, and
 * that pins user_in and addr come from outside and need synchronising.
 */
`timescale 1ns/1ps
`include "smcr_regs.vh"
module smcr_config_bank (
    clk_sys,
    rst_n,
    prog_sel,
    prog_write,
    prog_addr,
    prog_wdata,
    prog_rdata,
    prog_err,
    ctrl_state,
    nand_if1,
    cfg_width,
    boot_width_tie_sram,
    boot_width_tie_nand,
    addr_match_tie,
    addr_mask_tie,
    user_in,
    mem_addr_hi,
    xfer_start,
    xfer_write,
    burst_done,
    beat_count,
    chip_hit,
    idle_cs,
    adv_n,
    baa_n,
    we_delay,
    bls_follow_we,
    split_beats
);
    input  wire        clk_sys;
    input  wire        rst_n;
    input  wire        prog_sel;
    input  wire        prog_write;
    input  wire [11:0] prog_addr;
    input  wire [31:0] prog_wdata;
    output reg  [31:0] prog_rdata;
    output reg         prog_err;
    input  wire [1:0]  ctrl_state;
    input  wire        nand_if1;
    input  wire [1:0]  cfg_width;
    input  wire [1:0]  boot_width_tie_sram;
    input  wire        boot_width_tie_nand;
    input  wire [7:0]  addr_match_tie;
    input  wire [7:0]  addr_mask_tie;
    input  wire [7:0]  user_in;
    input  wire [7:0]  mem_addr_hi;
    input  wire        xfer_start;
    input  wire        xfer_write;
    input  wire        burst_done;
    input  wire [8:0]  beat_count;
    output reg         chip_hit;
    output reg         idle_cs;
    output reg         adv_n;
    output reg         baa_n;
    output reg  [1:0]  we_delay;
    output reg         bls_follow_we;
    output reg  [8:0]  split_beats;

    reg  [3:0]  idle_period_r;
    reg  [31:0] set_cycles_r;
    reg  [15:0] set_opmode_r;
    reg  [20:0] sram_timing_r;
    reg  [23:0] nand_timing_r;
    reg  [15:0] opmode_r;
    reg         boot_seen_r;
    reg  [7:0]  user_meta_r;
    reg  [7:0]  user_sync_r;
    reg  [7:0]  addr_meta_r;
    reg  [7:0]  addr_sync_r;
    reg  [31:0] rdata_nxt;
    reg         err_nxt;
    reg  [8:0]  bl_beats;
    reg  [8:0]  split_nxt;
    reg  [2:0]  eff_align;
    reg         eff_sync;
    reg  [2:0]  eff_bl;
    wire        idle_req;
    wire        in_reset;
    wire        in_lowpower;
    wire        wr;
    wire        cont_burst;
    wire        counted_burst;
    wire [1:0]  boot_width;

    assign in_reset    = (ctrl_state == `SMCR_ST_RESET);
    assign in_lowpower = (ctrl_state == `SMCR_ST_LOWPOWER);
    assign wr          = prog_sel & prog_write;
    assign boot_width  = nand_if1 ? {1'b0, boot_width_tie_nand} : boot_width_tie_sram;

    // a continuous burst ends for counting at each 32-beat slice
    assign cont_burst    = (opmode_r[`SMCR_OM_RBL_HI:`SMCR_OM_RBL_LO] == `SMCR_BL_CONT) |
                           (opmode_r[`SMCR_OM_WBL_HI:`SMCR_OM_WBL_LO] == `SMCR_BL_CONT);
    assign counted_burst = burst_done |
                           (cont_burst & (beat_count == `SMCR_CONT_LIMIT));

    smcr_idle_counter u_idle (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .period     (idle_period_r),
        .burst_done (counted_burst),
        .idle_req   (idle_req)
    );

    // pins from outside pass two flops; only the second is read
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            user_meta_r <= 8'h00;
            user_sync_r <= 8'h00;
            addr_meta_r <= 8'h00;
            addr_sync_r <= 8'h00;
        end else begin
            user_meta_r <= user_in;
            user_sync_r <= user_meta_r;
            addr_meta_r <= mem_addr_hi;
            addr_sync_r <= addr_meta_r;
        end
    end

    // register writes; readback copies change only on direct command, apart from the boot width capture
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idle_period_r <= 4'h0;
            set_cycles_r  <= 32'h00000000;
            set_opmode_r  <= 16'h0000;
            sram_timing_r <= `SMCR_SRAM_TIMING_RST;
            nand_timing_r <= `SMCR_NAND_TIMING_RST;
            opmode_r      <= 16'h0000;
            boot_seen_r   <= 1'b0;
        end else begin
            // width straps are caught once, after reset release
            if (!boot_seen_r) begin
                boot_seen_r                           <= 1'b1;
                opmode_r[`SMCR_OM_MW_HI:`SMCR_OM_MW_LO] <= boot_width;
            end
            if (wr && !in_reset && !in_lowpower) begin
                case (prog_addr)
                    `SMCR_OFF_IDLE_PERIOD: begin
                        idle_period_r <= prog_wdata[3:0];
                    end
                    `SMCR_OFF_SET_CYCLES: begin
                        set_cycles_r <= prog_wdata;
                    end
                    `SMCR_OFF_SET_OPMODE: begin
                        set_opmode_r <= prog_wdata[15:0];
                    end
                    `SMCR_OFF_DIRECT_CMD: begin
                        sram_timing_r <= set_cycles_r[20:0];
                        nand_timing_r <= set_cycles_r[23:0];
                        if (nand_if1) begin
                            opmode_r <= set_opmode_r & `SMCR_OM_NAND_KEEP;
                        end else begin
                            opmode_r <= set_opmode_r;
                        end
                    end
                    default: begin
                        // read-only and unmapped offsets keep their contents
                        idle_period_r <= idle_period_r;
                    end
                endcase
            end
        end
    end

    // read path; refusal shows as prog_err with zero data
    always @* begin
        rdata_nxt = 32'h00000000;
        err_nxt   = 1'b0;
        case (prog_addr)
            `SMCR_OFF_IDLE_PERIOD: begin
                if (in_reset || in_lowpower) begin
                    err_nxt = 1'b1;
                end else begin
                    rdata_nxt = {28'h0000000, idle_period_r};
                end
            end
            `SMCR_OFF_SRAM_TIMING: begin
                if (in_reset) begin
                    err_nxt = 1'b1;
                end else begin
                    rdata_nxt = {11'h000, sram_timing_r};
                end
            end
            `SMCR_OFF_NAND_TIMING: begin
                if (in_reset) begin
                    err_nxt = 1'b1;
                end else begin
                    rdata_nxt = {8'h00, nand_timing_r};
                end
            end
            `SMCR_OFF_OPMODE: begin
                if (in_reset) begin
                    err_nxt = 1'b1;
                end else begin
                    rdata_nxt = {addr_match_tie, addr_mask_tie, opmode_r};
                end
            end
            `SMCR_OFF_GPIN: begin
                rdata_nxt = {24'h000000, user_sync_r};
            end
            `SMCR_OFF_DIRECT_CMD,
            `SMCR_OFF_SET_CYCLES,
            `SMCR_OFF_SET_OPMODE: begin
                rdata_nxt = 32'h00000000;
            end
            default: begin
                err_nxt = 1'b1;
            end
        endcase
        // writes to read-only registers are refused without effect
        if (prog_write && (prog_addr == `SMCR_OFF_SRAM_TIMING ||
                           prog_addr == `SMCR_OFF_NAND_TIMING ||
                           prog_addr == `SMCR_OFF_OPMODE ||
                           prog_addr == `SMCR_OFF_GPIN)) begin
            err_nxt   = 1'b1;
            rdata_nxt = 32'h00000000;
        end
    end

    // burst length and split boundary for the current transfer direction
    always @* begin
        eff_sync  = xfer_write ? opmode_r[`SMCR_OM_WSYNC] : opmode_r[`SMCR_OM_RSYNC];
        eff_bl    = xfer_write ? opmode_r[`SMCR_OM_WBL_HI:`SMCR_OM_WBL_LO]
                               : opmode_r[`SMCR_OM_RBL_HI:`SMCR_OM_RBL_LO];
        // async transfers behave as if aligned to the memory burst
        eff_align = eff_sync ? opmode_r[`SMCR_OM_ALIGN_HI:`SMCR_OM_ALIGN_LO]
                             : `SMCR_AL_MEMBURST;
        case (eff_bl)
            `SMCR_BL_1:    bl_beats = 9'h001;
            `SMCR_BL_4:    bl_beats = 9'h004;
            `SMCR_BL_8:    bl_beats = 9'h008;
            `SMCR_BL_16:   bl_beats = 9'h010;
            `SMCR_BL_32:   bl_beats = 9'h020;
            `SMCR_BL_CONT: bl_beats = `SMCR_CONT_LIMIT;
            default:       bl_beats = 9'h001;
        endcase
        // zero means bursts may cross any boundary
        case (eff_align)
            `SMCR_AL_NONE:     split_nxt = 9'h000;
            `SMCR_AL_MEMBURST: split_nxt = bl_beats;
            `SMCR_AL_64:       split_nxt = 9'h040;
            `SMCR_AL_128:      split_nxt = 9'h080;
            `SMCR_AL_256:      split_nxt = 9'h100;
            default:           split_nxt = 9'h000;
        endcase
    end

    // registered outputs towards the programming port and memory pins
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prog_rdata    <= 32'h00000000;
            prog_err      <= 1'b0;
            chip_hit      <= 1'b0;
            idle_cs       <= 1'b0;
            adv_n         <= 1'b1;
            baa_n         <= 1'b1;
            we_delay      <= 2'h0;
            bls_follow_we <= 1'b0;
            split_beats   <= 9'h000;
        end else begin
            prog_rdata    <= prog_sel ? rdata_nxt : 32'h00000000;
            prog_err      <= prog_sel & err_nxt;
            chip_hit      <= ((addr_sync_r ^ addr_match_tie) & addr_mask_tie) == 8'h00;
            idle_cs       <= idle_req;
            adv_n         <= ~(opmode_r[`SMCR_OM_ADV] & xfer_start);
            baa_n         <= ~opmode_r[`SMCR_OM_BAA];
            we_delay      <= sram_timing_r[`SMCR_ST_WE_TIME] ? 2'h0 : `SMCR_WE_DELAY;
            bls_follow_we <= opmode_r[`SMCR_OM_BLS];
            split_beats   <= split_nxt;
        end
    end
endmodule // smcr_config_bank

// ===== smcr_regs.vh
/*
 * smcr_regs.vh: register offsets, field positions, reset values and
 * encodings of the static memory configuration readback bank.
 * Assumes the includer has no other macros with the smcr_ prefix.
 */
`ifndef SMCR_REGS_VH
`define SMCR_REGS_VH

// register offsets on the programming port (byte addresses)
`define SMCR_OFF_IDLE_PERIOD   12'h0E0
`define SMCR_OFF_SRAM_TIMING   12'h100
`define SMCR_OFF_NAND_TIMING   12'h180
`define SMCR_OFF_OPMODE        12'h104
`define SMCR_OFF_GPIN          12'h200
`define SMCR_OFF_DIRECT_CMD    12'h010
`define SMCR_OFF_SET_CYCLES    12'h014
`define SMCR_OFF_SET_OPMODE    12'h018

// controller states
`define SMCR_ST_RESET          2'h0
`define SMCR_ST_READY          2'h1
`define SMCR_ST_LOWPOWER       2'h2

// operating mode field positions
`define SMCR_OM_MATCH_HI       31
`define SMCR_OM_MATCH_LO       24
`define SMCR_OM_MASK_HI        23
`define SMCR_OM_MASK_LO        16
`define SMCR_OM_ALIGN_HI       15
`define SMCR_OM_ALIGN_LO       13
`define SMCR_OM_BLS            12
`define SMCR_OM_ADV            11
`define SMCR_OM_BAA            10
`define SMCR_OM_WBL_HI         9
`define SMCR_OM_WBL_LO         7
`define SMCR_OM_WSYNC          6
`define SMCR_OM_RBL_HI         5
`define SMCR_OM_RBL_LO         3
`define SMCR_OM_RSYNC          2
`define SMCR_OM_MW_HI          1
`define SMCR_OM_MW_LO          0
`define SMCR_OM_NAND_KEEP      16'h0003

// sram timing: we_time bit and valid field width; nand timing width
`define SMCR_ST_WE_TIME        20
`define SMCR_ST_SRAM_BITS      21
`define SMCR_ST_NAND_BITS      24
`define SMCR_SRAM_TIMING_RST   21'h0492A2
`define SMCR_NAND_TIMING_RST   24'h0012A2

// burst length codes
`define SMCR_BL_1              3'h0
`define SMCR_BL_4              3'h1
`define SMCR_BL_8              3'h2
`define SMCR_BL_16             3'h3
`define SMCR_BL_32             3'h4
`define SMCR_BL_CONT           3'h5
`define SMCR_CONT_LIMIT        9'h020

// burst alignment codes
`define SMCR_AL_NONE           3'h0
`define SMCR_AL_MEMBURST       3'h1
`define SMCR_AL_64             3'h2
`define SMCR_AL_128            3'h3
`define SMCR_AL_256            3'h4

// write strobe delay after chip select when we_time is 0
`define SMCR_WE_DELAY          2'h2

`endif

// ===== smcr_idle_counter.v
/*
 * smcr_idle_counter.v: counts consecutive bursts on memory interface 1
 * and requests one idle chip-select cycle after the programmed number.
 * Assumes burst_done pulses once per burst from the memory-side engine.
 */
`timescale 1ns/1ps
module smcr_idle_counter (
    clk_sys,
    rst_n,
    period,
    burst_done,
    idle_req
);
    input  wire       clk_sys;
    input  wire       rst_n;
    input  wire [3:0] period;
    input  wire       burst_done;
    output reg        idle_req;

    reg [3:0] count_r;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_r  <= 4'h0;
            idle_req <= 1'b0;
        end else begin
            idle_req <= 1'b0;
            if (period == 4'h0) begin
                count_r <= 4'h0;
            end else if (burst_done) begin
                if (count_r + 4'h1 >= period) begin
                    count_r  <= 4'h0;
                    idle_req <= 1'b1;
                end else begin
                    count_r <= count_r + 4'h1;
                end
            end
        end
    end
endmodule // smcr_idle_counter

// ===== smcr_config_bank_sva.sv
/* smcr_config_bank_sva.sv: port-level assertions on the configuration bank.
   Assumes the bank's ports only; attached by the bind at the foot. */
`timescale 1ns/1ps
module smcr_config_bank_chk (
    input wire        clk_sys,
    input wire        rst_n,
    input wire        prog_sel,
    input wire        prog_write,
    input wire [11:0] prog_addr,
    input wire [31:0] prog_rdata,
    input wire        prog_err,
    input wire [1:0]  ctrl_state,
    input wire        xfer_start,
    input wire        burst_done,
    input wire [8:0]  beat_count,
    input wire        idle_cs,
    input wire        adv_n,
    input wire [1:0]  we_delay,
    input wire [8:0]  split_beats
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_rd(a);
        prog_sel && !prog_write && prog_addr == a;
    endsequence
    sequence s_rb_reset;
        prog_sel && ctrl_state == 2'h0 &&
        (prog_addr == 12'h100 || prog_addr == 12'h104 || prog_addr == 12'h180);
    endsequence
    gpin_read_a: assert property (s_rd(12'h200) |=> !prog_err && prog_rdata[31:8] == 24'h0)
        else $error("input sample read gave error or upper bits");
    idle_refuse_a: assert property (prog_sel && prog_addr == 12'h0E0 && ctrl_state != 2'h1
        |=> prog_err && prog_rdata == 32'h0) else $error("idle period access not refused");
    rb_refuse_a: assert property (s_rb_reset |=> prog_err)
        else $error("readback access in reset state not refused");
    ro_write_a: assert property (prog_sel && prog_write && prog_addr == 12'h200 |=> prog_err)
        else $error("write to input sample not refused");
    // idle_cs trails the counted burst by two registers: counter, then output flop
    idle_cause_a: assert property (idle_cs |-> $past(burst_done, 2) || $past(beat_count, 2) == 9'h020)
        else $error("idle cycle without a finished burst");
    adv_cause_a: assert property (!adv_n |-> $past(xfer_start))
        else $error("address valid low outside transfer start");
    we_delay_a: assert property (we_delay == 2'h2 || we_delay == 2'h0)
        else $error("write strobe delay not 0 or 2");
    split_legal_a: assert property (split_beats inside {9'h000, 9'h001, 9'h004, 9'h008,
        9'h010, 9'h020, 9'h040, 9'h080, 9'h100}) else $error("split boundary illegal");
endmodule // smcr_config_bank_chk
bind smcr_config_bank smcr_config_bank_chk smcr_config_bank_chk_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .prog_sel(prog_sel), .prog_write(prog_write), .prog_addr(prog_addr),
    .prog_rdata(prog_rdata), .prog_err(prog_err), .ctrl_state(ctrl_state),
    .xfer_start(xfer_start), .burst_done(burst_done), .beat_count(beat_count),
    .idle_cs(idle_cs), .adv_n(adv_n), .we_delay(we_delay), .split_beats(split_beats));

// ===== smcr_mem_model.sv
/* smcr_mem_model.sv: memory-side burst engine running back-to-back bursts.
   Assumes go is a one-cycle pulse from the bench while idle. */
`timescale 1ns/1ps
module smcr_mem_model #(
    parameter [8:0] BLEN = 9'h002
) (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       go,
    input  wire [3:0] n_bursts,
    output wire       xfer_start,
    output wire       xfer_write,
    output wire       burst_done,
    output wire [8:0] beat_count,
    output wire       busy
);
    reg [3:0] left_r;
    reg [8:0] beat_r;
    assign busy       = (left_r != 4'h0);
    assign xfer_start = busy && (beat_r == 9'h000);
    assign burst_done = busy && (beat_r == BLEN);
    assign beat_count = beat_r;
    assign xfer_write = 1'b0;
    // a fresh burst starts right after the last beat, so bursts are consecutive
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            left_r <= 4'h0;
            beat_r <= 9'h000;
        end else if (go) begin
            left_r <= n_bursts;
            beat_r <= 9'h000;
        end else if (burst_done) begin
            left_r <= left_r - 4'h1;
            beat_r <= 9'h000;
        end else if (busy) begin
            beat_r <= beat_r + 9'h001;
        end
    end
endmodule // smcr_mem_model

// ===== tb_smcr_config_bank.sv
/* tb_smcr_config_bank.sv: self-checking bench for the configuration bank.
   Assumes the memory-side model drives the burst engine inputs. */
`timescale 1ns/1ps
module tb_smcr_config_bank;
    reg         clk_sys = 1'b0;
    reg         rst_n = 1'b0;
    reg         prog_sel = 1'b0;
    reg         prog_write = 1'b0;
    reg  [11:0] prog_addr = 12'h000;
    reg  [31:0] prog_wdata = 32'h0;
    reg  [1:0]  ctrl_state = 2'h0;
    reg         nand_if1 = 1'b0;
    reg  [7:0]  user_in = 8'h96;
    reg  [7:0]  mem_addr_hi = 8'hA3;
    reg         go = 1'b0;
    reg  [3:0]  n_bursts = 4'h0;
    reg  [31:0] rd;
    reg  [31:0] er;
    integer     errors = 0;
    integer     checked = 0;
    integer     i;
    wire [31:0] prog_rdata;
    wire [8:0]  beat_count, split_beats;
    wire [1:0]  we_delay;
    wire        prog_err, xfer_start, xfer_write, burst_done, busy, chip_hit;
    wire        idle_cs, adv_n, baa_n, bls_follow_we;
    reg  [8:0]  al_tab [0:4];
    reg  [8:0]  bl_tab [0:5];
    always #12.5 clk_sys = ~clk_sys;
    smcr_config_bank smcr_config_bank_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .prog_sel(prog_sel), .prog_write(prog_write), .prog_addr(prog_addr),
        .prog_wdata(prog_wdata), .prog_rdata(prog_rdata), .prog_err(prog_err),
        .ctrl_state(ctrl_state), .nand_if1(nand_if1), .cfg_width(2'h2),
        .boot_width_tie_sram(2'h2), .boot_width_tie_nand(1'b1), .addr_match_tie(8'hA5),
        .addr_mask_tie(8'hF0), .user_in(user_in), .mem_addr_hi(mem_addr_hi),
        .xfer_start(xfer_start), .xfer_write(xfer_write), .burst_done(burst_done),
        .beat_count(beat_count), .chip_hit(chip_hit), .idle_cs(idle_cs), .adv_n(adv_n),
        .baa_n(baa_n), .we_delay(we_delay), .bls_follow_we(bls_follow_we),
        .split_beats(split_beats));
    smcr_mem_model smcr_mem_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .go(go),
        .n_bursts(n_bursts), .xfer_start(xfer_start), .xfer_write(xfer_write),
        .burst_done(burst_done), .beat_count(beat_count), .busy(busy));
    task end_sim;
        begin
            $display("checked=%0d errors=%0d", checked, errors);
            if (errors == 0 && checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // answer is read 1 ns after the taking edge, where it stands
    task acc(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk_sys);
            prog_sel <= 1'b1;
            prog_write <= w;
            prog_addr <= a;
            prog_wdata <= d;
            @(posedge clk_sys);
            prog_sel <= 1'b0;
            #1;
            rd = prog_rdata;
            er = {31'h0, prog_err};
        end
    endtask
    task cfg(input [31:0] v, input [8:0] exp);
        begin
            acc(1'b1, 12'h018, v);
            acc(1'b1, 12'h010, 32'h0);
            acc(1'b0, 12'h104, 32'h0);
            chk(rd, {16'hA5F0, v[15:0]});
            chk({23'h0, split_beats}, {23'h0, exp});
        end
    endtask
    task run(input [3:0] n, input [31:0] e_idle, input [31:0] e_adv);
        integer k, q, ni, na;
        begin
            ni = 0;
            na = 0;
            q = 0;
            @(posedge clk_sys);
            n_bursts <= n;
            go <= 1'b1;
            @(posedge clk_sys);
            go <= 1'b0;
            for (k = 0; k < 200 && q < 4; k = k + 1) begin
                @(posedge clk_sys);
                #1;
                ni = ni + idle_cs;
                na = na + !adv_n;
                q = busy ? 0 : q + 1;
            end
            if (k == 200) begin
                errors = errors + 1;
                end_sim;
            end else begin
                chk(ni, e_idle);
                chk(na, e_adv);
            end
        end
    endtask
    initial begin
        al_tab[0] = 9'h000; al_tab[1] = 9'h004; al_tab[2] = 9'h040;
        al_tab[3] = 9'h080; al_tab[4] = 9'h100;
        bl_tab[0] = 9'h001; bl_tab[1] = 9'h004; bl_tab[2] = 9'h008;
        bl_tab[3] = 9'h010; bl_tab[4] = 9'h020; bl_tab[5] = 9'h020;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        acc(1'b0, 12'h104, 32'h0); chk(er, 32'h1);
        acc(1'b0, 12'h0E0, 32'h0); chk(er, 32'h1);
        acc(1'b0, 12'h200, 32'h0); chk(rd, 32'h96);
        ctrl_state <= 2'h2;
        user_in <= 8'h3C;
        acc(1'b0, 12'h0E0, 32'h0); chk(er, 32'h1);
        acc(1'b0, 12'h100, 32'h0); chk(rd, 32'h0492A2);
        acc(1'b0, 12'h200, 32'h0); chk(rd, 32'h3C);
        ctrl_state <= 2'h1;
        acc(1'b0, 12'h180, 32'h0); chk(rd, 32'h0012A2);
        acc(1'b0, 12'h104, 32'h0); chk(rd, 32'hA5F00002);
        acc(1'b1, 12'h200, 32'hFF); chk(er, 32'h1);
        acc(1'b1, 12'h100, 32'h0); chk(er, 32'h1);
        acc(1'b0, 12'h3FC, 32'h0); chk(er, 32'h1);
        chk(we_delay, 32'h2);
        acc(1'b1, 12'h014, 32'h001AB537);
        acc(1'b0, 12'h100, 32'h0); chk(rd, 32'h0492A2);
        acc(1'b1, 12'h010, 32'h0);
        acc(1'b0, 12'h100, 32'h0); chk(rd, 32'h001AB537);
        chk(we_delay, 32'h0);
        chk(chip_hit, 32'h1);
        mem_addr_hi <= 8'hB5;
        repeat (6) @(posedge clk_sys);
        chk(chip_hit, 32'h0);
        cfg(32'h5DED, 9'h040);
        chk(bls_follow_we, 32'h1);
        chk(baa_n, 32'h0);
        for (i = 0; i < 5; i = i + 1)
            cfg((i << 13) | 32'h0CCD, al_tab[i]);
        for (i = 0; i < 6; i = i + 1)
            cfg(32'h2044 | (i << 7) | (i << 3) | (i % 3), bl_tab[i]);
        // async both ways: burst alignment is forced even with align 000
        cfg(32'h0C89, 9'h004);
        chk(bls_follow_we, 32'h0);
        acc(1'b1, 12'h0E0, 32'h3);
        acc(1'b0, 12'h0E0, 32'h0); chk(rd & 32'hF, 32'h3);
        run(4'h6, 2, 6);
        acc(1'b1, 12'h0E0, 32'h0);
        run(4'h4, 0, 4);
        acc(1'b1, 12'h0E0, 32'h1);
        run(4'h5, 5, 5);
        nand_if1 <= 1'b1;
        acc(1'b1, 12'h014, 32'h00F2B537);
        acc(1'b1, 12'h010, 32'h0);
        acc(1'b0, 12'h180, 32'h0); chk(rd, 32'h00F2B537);
        acc(1'b1, 12'h018, 32'h5DED);
        acc(1'b1, 12'h010, 32'h0);
        acc(1'b0, 12'h104, 32'h0); chk(rd, 32'hA5F00001);
        end_sim;
    end
endmodule // tb_smcr_config_bank
